// [eeprom_pkg.sv]
/*
  Constants and types for the two-wire serial EEPROM slave.
  Assumes a 250 MHz reference clock and a separate link sampling clock.
*/
package eeprom_pkg;
  localparam int REF_PERIOD_NS   = 4;
  localparam int LINK_PERIOD_PS  = 15000;
  localparam int FILTER_PS       = 50000;
  localparam int FILTER_CYC      = (FILTER_PS + LINK_PERIOD_PS - 1) / LINK_PERIOD_PS;
  localparam int WRITE_CYCLE_NS  = 5000000;
  localparam int WRITE_CYCLE_CYC = WRITE_CYCLE_NS / REF_PERIOD_NS;
  localparam int POR_GUARD_CYC   = 16;
  localparam int ADDR_W          = 8;
  localparam int PAGE_OFS_W      = 4;
  localparam int BYTE_BITS       = 8;
  localparam int MEM_DEPTH       = 256;
  // Type code value is arbitrary
  localparam logic [3:0] TYPE_CODE_DEF = 4'h5;
  localparam logic [3:0] BYTE_DONE     = 4'h8;
  localparam logic [3:0] LAST_TX_BIT   = 4'h7;
  localparam int EV_START = 0;
  localparam int EV_STOP  = 1;
  localparam int EV_RISE  = 2;
  localparam int EV_FALL  = 3;
  typedef enum {ST_IDLE, ST_RX, ST_ACK, ST_TX, ST_MACK, ST_HOLD} link_state_t;
  typedef enum {RX_DEV, RX_ADDR, RX_DATA} rx_phase_t;
endpackage

// [eeprom_slave.sv]
/*
  Two-wire serial EEPROM slave: pin filtering, start/stop detection, polling,
  current, random and sequential reads, byte writes into a flip-flop array.
  Assumes SDA is open drain outside, scl/sda arrive asynchronously, and the
  link sampling clock is unrelated to the reference clock.
*/
`timescale 1ns/1ps
module eeprom_slave
  import eeprom_pkg::*;
#(
  parameter int         WRITE_CYCLES = eeprom_pkg::WRITE_CYCLE_CYC,
  parameter logic [3:0] TYPE_CODE    = eeprom_pkg::TYPE_CODE_DEF
) (
  input  wire logic       ref_clk_in,
  input  wire logic       rst_n_in,
  input  wire logic       ce_in,
  input  wire logic       link_clk_in,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe_out,
  input  wire logic [2:0] chip_select_straps_in,
  output logic            busy_out
);
  import eeprom_pkg::*;

  localparam int FW = $clog2(FILTER_CYC + 1);
  localparam int PW = $clog2(POR_GUARD_CYC + 1);
  localparam int BW = $clog2(WRITE_CYCLES + 1);
  localparam logic [FW-1:0] FILT_LAST = FW'(FILTER_CYC - 1);
  localparam logic [PW-1:0] POR_LAST  = PW'(POR_GUARD_CYC - 1);
  localparam logic [BW-1:0] BUSY_LAST = BW'(WRITE_CYCLES - 1);

  if (WRITE_CYCLES < 1) begin : g_bad_cycles
    $error("WRITE_CYCLES must be at least one");
  end

  function automatic logic [ADDR_W-1:0] page_inc(input logic [ADDR_W-1:0] a);
    page_inc = {a[ADDR_W-1:PAGE_OFS_W], a[PAGE_OFS_W-1:0] + 4'h1};
  endfunction

  // Link domain: reset release, synchronisers, filters, condition detection
  logic            lrst_s1;
  logic            link_rst_n;
  logic [1:0]      raw_s1;
  logic [1:0]      raw_s2;
  logic [1:0]      flt_reg;
  logic [1:0]      prev_reg;
  logic [FW-1:0]   flt_cnt_reg [2];
  logic [PW-1:0]   por_cnt_reg;
  logic            por_ok_reg;
  logic [3:0]      tgl_reg;
  logic            bit_reg;
  logic            oe_s1;
  logic            oe_s2;
  logic            oe_reg;

  always_ff @(posedge link_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      lrst_s1    <= 1'b0;
      link_rst_n <= 1'b0;
    end else begin
      lrst_s1    <= 1'b1;
      link_rst_n <= lrst_s1;
    end
  end

  always_ff @(posedge link_clk_in or negedge link_rst_n) begin
    if (!link_rst_n) begin
      raw_s1 <= 2'h3;
      raw_s2 <= 2'h3;
    end else begin
      raw_s1 <= {sda_in, scl_in};
      raw_s2 <= raw_s1;
    end
  end

  for (genvar i = 0; i < 2; i++) begin : g_filt
    wire differs = raw_s2[i] != flt_reg[i];
    always_ff @(posedge link_clk_in or negedge link_rst_n) begin
      if (!link_rst_n) begin
        flt_cnt_reg[i] <= '0;
        flt_reg[i]     <= 1'b1;
      end else if (!differs) begin
        flt_cnt_reg[i] <= '0;
      end else if (flt_cnt_reg[i] == FILT_LAST) begin
        flt_cnt_reg[i] <= '0;
        flt_reg[i]     <= raw_s2[i];
      end else begin
        flt_cnt_reg[i] <= flt_cnt_reg[i] + 1'b1;
      end
    end
  end

  // Bus idle high for a guard time before any condition is honoured
  wire lines_high = flt_reg[0] && flt_reg[1];
  always_ff @(posedge link_clk_in or negedge link_rst_n) begin
    if (!link_rst_n) begin
      por_cnt_reg <= '0;
      por_ok_reg  <= 1'b0;
    end else if (!por_ok_reg) begin
      por_cnt_reg <= lines_high ? por_cnt_reg + 1'b1 : '0;
      por_ok_reg  <= lines_high && (por_cnt_reg == POR_LAST);
    end
  end

  wire scl_hold  = prev_reg[0] && flt_reg[0];
  wire start_det = por_ok_reg && scl_hold && prev_reg[1] && !flt_reg[1];
  wire stop_det  = por_ok_reg && scl_hold && !prev_reg[1] && flt_reg[1];
  wire rise_det  = por_ok_reg && !prev_reg[0] && flt_reg[0];
  wire fall_det  = por_ok_reg && prev_reg[0] && !flt_reg[0];

  always_ff @(posedge link_clk_in or negedge link_rst_n) begin
    if (!link_rst_n) begin
      prev_reg <= 2'h3;
      tgl_reg  <= 4'h0;
      bit_reg  <= 1'b1;
    end else begin
      prev_reg <= flt_reg;
      tgl_reg  <= tgl_reg ^ {fall_det, rise_det, stop_det, start_det};
      if (rise_det) begin
        bit_reg <= flt_reg[1];
      end
    end
  end

  // Drive enable crosses back as a level; output is a plain flop
  always_ff @(posedge link_clk_in or negedge link_rst_n) begin
    if (!link_rst_n) begin
      oe_s1      <= 1'b0;
      oe_s2      <= 1'b0;
      sda_oe_out <= 1'b0;
    end else begin
      oe_s1      <= oe_reg;
      oe_s2      <= oe_s1;
      sda_oe_out <= oe_s2;
    end
  end

  assign sda_out = 1'b0;

  // Reference domain
  logic [3:0]         t_s1;
  logic [3:0]         t_s2;
  logic [3:0]         t_s3;
  logic               bit_s1;
  logic               bit_s2;
  logic [2:0]         strap_s1;
  logic [2:0]         strap_s2;
  link_state_t        state_reg;
  link_state_t        state_next;
  rx_phase_t          phase_reg;
  rx_phase_t          phase_next;
  logic [3:0]         cnt_reg;
  logic [3:0]         cnt_next;
  logic [7:0]         shift_reg;
  logic [7:0]         shift_next;
  logic [ADDR_W-1:0]  addr_reg;
  logic [ADDR_W-1:0]  addr_next;
  logic               oe_next;
  logic               read_reg;
  logic               read_next;
  logic               wrote_reg;
  logic               wrote_next;
  logic               busy_reg;
  logic [BW-1:0]      busy_cnt_reg;
  logic [BYTE_BITS-1:0] mem [MEM_DEPTH];

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      t_s1     <= 4'h0;
      t_s2     <= 4'h0;
      t_s3     <= 4'h0;
      bit_s1   <= 1'b1;
      bit_s2   <= 1'b1;
      strap_s1 <= 3'h0;
      strap_s2 <= 3'h0;
    end else if (ce_in) begin
      t_s1     <= tgl_reg;
      t_s2     <= t_s1;
      t_s3     <= t_s2;
      bit_s1   <= bit_reg;
      bit_s2   <= bit_s1;
      strap_s1 <= chip_select_straps_in;
      strap_s2 <= strap_s1;
    end
  end

  wire [3:0] ev       = (t_s2 ^ t_s3) & {4{ce_in}};
  wire       ev_start = ev[EV_START];
  wire       ev_stop  = ev[EV_STOP];
  wire       ev_rise  = ev[EV_RISE];
  wire       ev_fall  = ev[EV_FALL];
  wire       byte_end = ev_fall && state_reg == ST_RX && cnt_reg == BYTE_DONE;
  wire       type_ok  = shift_reg[7:4] == TYPE_CODE;
  wire       sel_ok   = shift_reg[3:1] == strap_s2;
  wire       dev_ok   = type_ok && sel_ok && !busy_reg;
  wire       dev_end  = byte_end && phase_reg == RX_DEV;
  wire       mem_we   = byte_end && phase_reg == RX_DATA;
  wire       load_rd  = ev_fall && state_reg == ST_ACK && read_reg;
  wire [7:0] rd_byte  = mem[addr_reg];
  wire       launch   = ev_stop && wrote_reg && !busy_reg;

  always_comb begin
    state_next = state_reg;
    phase_next = phase_reg;
    cnt_next   = cnt_reg;
    shift_next = shift_reg;
    addr_next  = addr_reg;
    oe_next    = oe_reg;
    read_next  = read_reg;
    wrote_next = wrote_reg;
    if (ev_start) begin
      state_next = ST_RX;
      phase_next = RX_DEV;
      cnt_next   = 4'h0;
      oe_next    = 1'b0;
    end else if (ev_stop) begin
      state_next = ST_IDLE;
      oe_next    = 1'b0;
      wrote_next = 1'b0;
    end else if (ev_rise) begin
      if (state_reg == ST_RX) begin
        shift_next = {shift_reg[6:0], bit_s2};
        cnt_next   = cnt_reg + 4'h1;
      end else if (state_reg == ST_MACK) begin
        state_next = bit_s2 ? ST_HOLD : ST_ACK;
      end
    end else if (ev_fall) begin
      unique case (state_reg)
        ST_RX: begin
          if (cnt_reg == BYTE_DONE) begin
            if (phase_reg == RX_DEV && !dev_ok) begin
              state_next = ST_HOLD;
            end else begin
              state_next = ST_ACK;
              oe_next    = 1'b1;
            end
            if (phase_reg == RX_DEV) begin
              read_next = shift_reg[0];
            end
            if (phase_reg == RX_ADDR) begin
              addr_next = shift_reg;
            end
            if (phase_reg == RX_DATA) begin
              addr_next  = page_inc(addr_reg);
              wrote_next = 1'b1;
            end
          end
        end
        ST_ACK: begin
          cnt_next = 4'h0;
          if (read_reg) begin
            state_next = ST_TX;
            shift_next = rd_byte;
            addr_next  = addr_reg + 8'h01;
            oe_next    = !rd_byte[7];
          end else begin
            state_next = ST_RX;
            oe_next    = 1'b0;
            phase_next = (phase_reg == RX_DEV) ? RX_ADDR : RX_DATA;
          end
        end
        ST_TX: begin
          cnt_next = cnt_reg + 4'h1;
          if (cnt_reg == LAST_TX_BIT) begin
            state_next = ST_MACK;
            oe_next    = 1'b0;
          end else begin
            shift_next = {shift_reg[6:0], 1'b0};
            oe_next    = !shift_reg[6];
          end
        end
        ST_IDLE, ST_MACK, ST_HOLD: begin
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_reg <= ST_IDLE;
      phase_reg <= RX_DEV;
      cnt_reg   <= 4'h0;
      shift_reg <= 8'h00;
      addr_reg  <= 8'h00;
      oe_reg    <= 1'b0;
      read_reg  <= 1'b0;
      wrote_reg <= 1'b0;
    end else if (ce_in) begin
      state_reg <= state_next;
      phase_reg <= phase_next;
      cnt_reg   <= cnt_next;
      shift_reg <= shift_next;
      addr_reg  <= addr_next;
      oe_reg    <= oe_next;
      read_reg  <= read_next;
      wrote_reg <= wrote_next;
    end
  end

  // Internally timed write cycle
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      busy_reg     <= 1'b0;
      busy_cnt_reg <= '0;
    end else if (ce_in) begin
      if (launch) begin
        busy_reg     <= 1'b1;
        busy_cnt_reg <= '0;
      end else if (busy_reg) begin
        busy_reg     <= busy_cnt_reg != BUSY_LAST;
        busy_cnt_reg <= busy_cnt_reg + 1'b1;
      end
    end
  end

  // Array is nonvolatile content, so it has no reset
  always_ff @(posedge ref_clk_in) begin
    if (mem_we) begin
      mem[addr_reg] <= shift_reg;
    end
  end

  assign busy_out = busy_reg;

  busy_nack_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    dev_end && busy_reg |=> !oe_reg && state_reg == ST_HOLD)
    else $error("device acknowledged while busy");
  sel_ack_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    dev_end && type_ok && sel_ok && !busy_reg |=> oe_reg && state_reg == ST_ACK)
    else $error("matching address word not acknowledged");
  sel_miss_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    dev_end && !(type_ok && sel_ok) |=> !oe_reg)
    else $error("mismatched address word acknowledged");
  stop_busy_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    launch |=> busy_reg && busy_cnt_reg == '0)
    else $error("stop after write data did not start write cycle");
  busy_end_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    ce_in && busy_reg && busy_cnt_reg == BUSY_LAST && !launch |=> !busy_reg)
    else $error("write cycle did not end on time");
  page_wrap_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    mem_we |=> addr_reg[7:4] == $past(addr_reg[7:4])
              && addr_reg[3:0] == $past(addr_reg[3:0]) + 4'h1)
    else $error("write address left its page");
  read_inc_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    load_rd |=> addr_reg == $past(addr_reg) + 8'h01 && state_reg == ST_TX)
    else $error("read address did not advance");
  first_bit_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    load_rd |=> oe_reg == !$past(rd_byte[7]))
    else $error("first read bit is not the msb");
  mack_nack_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    ev_rise && state_reg == ST_MACK && bit_s2 |=> !oe_reg ##1 !oe_reg)
    else $error("data line driven after no acknowledge");
  stop_idle_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    ev_stop |=> state_reg == ST_IDLE && !oe_reg)
    else $error("stop did not return to standby");
endmodule

// [bus_master_model.sv]
/*
  Two-wire bus master model: drives SCL and its own side of SDA.
  Assumes the wire is resolved outside as a pulled-up open-drain line.
*/
`timescale 1ns/1ps
module bus_master_model (
  input  wire logic clk_in,
  input  wire logic sda_in,
  output logic      scl_out,
  output logic      sda_out
);
  initial begin
    scl_out = 1'b1;
    sda_out = 1'b1;
  end
  task automatic w(input int n);
    repeat (n) @(negedge clk_in);
  endtask
  // Also serves as repeated start
  task automatic start();
    sda_out = 1'b1;
    w(100);
    scl_out = 1'b1;
    w(100);
    sda_out = 1'b0;
    w(100);
    scl_out = 1'b0;
  endtask
  // Start issued before the power-on guard has expired
  task automatic early_start();
    w(10);
    sda_out = 1'b0;
    w(100);
    scl_out = 1'b0;
  endtask
  task automatic stop();
    w(100);
    sda_out = 1'b0;
    w(100);
    scl_out = 1'b1;
    w(100);
    sda_out = 1'b1;
    w(100);
  endtask
  task automatic bit_io(input logic b, output logic r);
    w(100);
    sda_out = b;
    w(25);
    scl_out = 1'b1;
    w(50);
    r = sda_in;
    w(25);
    scl_out = 1'b0;
  endtask
  task automatic byte_tx(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r);
    end
    bit_io(1'b1, ack);
  endtask
  task automatic byte_rx(input logic ack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, d[i]);
    end
    bit_io(ack, r);
  endtask
  // Short SCL pulse that the pin filter must swallow
  task automatic glitch();
    scl_out = 1'b1;
    w(7);
    scl_out = 1'b0;
  endtask
endmodule

// [serial_eeprom_read_and_poll_test.sv]
/*
  Self-checking bench for the serial EEPROM slave: writes, polling,
  current, random and sequential reads. Assumes the bus master model.
*/
`timescale 1ns/1ps
module serial_eeprom_read_and_poll_test;
  import eeprom_pkg::*;
  localparam int WCYC = 3000;
  // Type code value is arbitrary
  localparam logic [3:0] TC = 4'h6;
  logic       ref_clk = 1'b0;
  logic       link_clk = 1'b0;
  logic       rst_n = 1'b0;
  logic       scl;
  logic       m_sda;
  logic       sda_o;
  logic       sda_oe;
  logic       busy;
  logic [2:0] straps = 3'h0;
  logic [7:0] mem_q [256];
  logic [7:0] cnt;
  logic       ack0;
  int         fails = 0;
  int         cmp_count = 0;
  int         cyc = 0;
  int         seed = 32'h477b;
  wire        sda_w = m_sda & ~(sda_oe & ~sda_o);

  eeprom_slave #(.WRITE_CYCLES(WCYC), .TYPE_CODE(TC)) dut (
    .ref_clk_in            (ref_clk),
    .rst_n_in              (rst_n),
    .ce_in                 (1'b1),
    .link_clk_in           (link_clk),
    .scl_in                (scl),
    .sda_in                (sda_w),
    .sda_out               (sda_o),
    .sda_oe_out            (sda_oe),
    .chip_select_straps_in (straps),
    .busy_out              (busy)
  );
  bus_master_model m (
    .clk_in  (ref_clk),
    .sda_in  (sda_w),
    .scl_out (scl),
    .sda_out (m_sda)
  );

  initial begin
    forever #2 ref_clk = ~ref_clk;
  end
  initial begin
    #3.3;
    forever #7.5 link_clk = ~link_clk;
  end

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 90000) begin
      fails++;
      finish_test();
    end
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  function automatic logic [7:0] dev(input logic rw);
    return {TC, straps, rw};
  endfunction
  // Write pointer stays inside its 16-byte page
  function automatic logic [7:0] pinc(input logic [7:0] p);
    return {p[7:4], p[3:0] + 4'h1};
  endfunction
  task automatic poll(input logic [7:0] dw, input logic exp);
    logic ack;
    m.start();
    m.byte_tx(dw, ack);
    m.stop();
    chk({7'h0, ack}, {7'h0, exp});
  endtask
  task automatic wr(input logic [7:0] p, input int n);
    logic       ack;
    logic [7:0] v;
    m.start();
    m.byte_tx(dev(1'b0), ack);
    chk({7'h0, ack}, 8'h00);
    m.byte_tx(p, ack);
    chk({7'h0, ack}, 8'h00);
    for (int i = 0; i < n; i++) begin
      v = 8'($random(seed));
      mem_q[p] = v;
      p = pinc(p);
      m.byte_tx(v, ack);
      chk({7'h0, ack}, 8'h00);
    end
    cnt = p;
    m.stop();
    m.w(60);
    chk({7'h0, busy}, 8'h01);
    poll(dev(1'b0), 1'b1);
    for (int i = 0; i < WCYC + 100 && busy !== 1'b0; i++) begin
      m.w(1);
    end
    poll(dev(1'b0), 1'b0);
  endtask
  task automatic rd(input int n);
    logic [7:0] v;
    for (int i = 0; i < n; i++) begin
      m.byte_rx(i == n - 1, v);
      chk(v, mem_q[cnt]);
      cnt = cnt + 8'h01;
    end
    m.w(100);
    chk({7'h0, sda_oe}, 8'h00);
    m.stop();
  endtask
  task automatic cur(input logic g, input int n);
    logic ack;
    m.start();
    if (g) begin
      m.glitch();
    end
    m.byte_tx(dev(1'b1), ack);
    chk({7'h0, ack}, 8'h00);
    rd(n);
  endtask
  task automatic rnd(input logic [7:0] p, input int n);
    logic ack;
    m.start();
    m.byte_tx(dev(1'b0), ack);
    m.byte_tx(p, ack);
    chk({7'h0, ack}, 8'h00);
    cnt = p;
    cur(1'b0, n);
  endtask

  initial begin
    straps = 3'($random(seed));
    repeat (16) @(negedge ref_clk);
    rst_n = 1'b1;
    m.early_start();
    m.byte_tx(dev(1'b0), ack0);
    m.stop();
    chk({7'h0, ack0}, 8'h01);
    m.w(200);
    chk({7'h0, sda_oe}, 8'h00);
    $display("test power_on_guard done");
    wr(8'hff, 3);
    $display("test write_page_wrap done");
    wr(8'h00, 1);
    $display("test write_poll done");
    rnd(8'hff, 1);
    cur(1'b1, 1);
    $display("test current_wrap done");
    rnd(8'hff, 2);
    rnd(8'hf0, 2);
    $display("test sequential done");
    poll({~TC, straps, 1'b0}, 1'b1);
    poll({TC, ~straps, 1'b0}, 1'b1);
    $display("test select_mismatch done");
    finish_test();
  end
endmodule
